// *** verilog/smbc_pkg.sv ***
package smbc_pkg;
	// register map, byte addresses
	localparam logic [11:0] SMBC_MASK_OFS = 12'hac0;
	localparam logic [11:0] SMBC_STAT_OFS = 12'hac8;
	localparam logic [11:0] SMBC_CTRL_OFS = 12'hacc;
	localparam int SMBC_ADDR_W = 12;
	// status flag positions
	localparam int SMBC_NAK_BIT = 25;
	localparam int SMBC_MIS_BIT = 27;
	localparam int SMBC_ICS_BIT = 28;
	localparam int SMBC_UIA_BIT = 29;
	localparam logic [31:0] SMBC_FLAG_MASK = 32'h3a00_0000;
	// control field positions
	localparam int SMBC_PRESC_LSB = 0;
	localparam int SMBC_PRESC_MSB = 15;
	localparam int SMBC_IGN_ARB_BIT = 16;
	localparam int SMBC_IGN_CSUM_BIT = 17;
	localparam int SMBC_SGD_LSB = 18;
	localparam int SMBC_MGD_LSB = 20;
	localparam int SMBC_TOD_BIT = 22;
	localparam logic [31:0] SMBC_CTRL_WMASK = 32'h007f_ffff;
	// boot prescale values
	localparam logic [15:0] SMBC_PRESC_SLOW = 16'h0139;
	localparam logic [15:0] SMBC_PRESC_FAST = 16'h0053;
	// timing
	localparam int SMBC_CLK_NS = 10;
	localparam int SMBC_TICK_NS = 32;
	localparam int SMBC_GL_LONG_NS = 1000;
	localparam int SMBC_GL_SHORT_NS = 100;
	localparam int SMBC_GL_LONG_CYC = (SMBC_GL_LONG_NS + SMBC_CLK_NS - 1) / SMBC_CLK_NS;
	localparam int SMBC_GL_SHORT_CYC = (SMBC_GL_SHORT_NS + SMBC_CLK_NS - 1) / SMBC_CLK_NS;
	localparam int SMBC_TIMEOUT_MS = 25;
	localparam int SMBC_TIMEOUT_CYC = SMBC_TIMEOUT_MS * 1000000 / SMBC_CLK_NS;
	localparam int SMBC_BOOT_WAIT = 3;

	typedef enum logic [1:0] {
		SMBC_GD_NORMAL = 2'b00,
		SMBC_GD_FAST   = 2'b01,
		SMBC_GD_OFF    = 2'b10,
		SMBC_GD_RSVD   = 2'b11
	} smbc_gd_t;

	typedef enum logic [1:0] {
		SMBC_CG_IDLE = 2'b00,
		SMBC_CG_LOW  = 2'b01,
		SMBC_CG_HIGH = 2'b10
	} smbc_cg_t;

	// glitch delay select to stable-cycle count, reserved acts as normal
	function automatic logic [6:0] smbc_glitch_cyc(input logic [1:0] sel);
		case (sel)
			SMBC_GD_FAST: smbc_glitch_cyc = 7'(SMBC_GL_SHORT_CYC);
			SMBC_GD_OFF:  smbc_glitch_cyc = 7'h00;
			default:      smbc_glitch_cyc = 7'(SMBC_GL_LONG_CYC);
		endcase
	endfunction
endpackage

// *** verilog/smbc_glitch.sv ***
`timescale 1ns/1ns
`default_nettype none
module smbc_glitch
	import smbc_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// raw line and delay select
	input  wire logic       pin_i,
	input  wire logic [1:0] sel,
	// filtered level
	output logic            lvl
);
	logic       s1_q;
	logic       s2_q;
	logic [6:0] cnt_q;
	logic [6:0] lim;

	assign lim = smbc_glitch_cyc(sel);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
		end
	end

	// [RULE10] stable-time filter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= 7'h00;
			lvl <= 1'b1;
		end else if (s2_q == lvl) begin
			cnt_q <= 7'h00;
		end else if (cnt_q + 7'h01 >= lim) begin
			cnt_q <= 7'h00;
			lvl <= s2_q;
		end else begin
			cnt_q <= cnt_q + 7'h01;
		end
	end

	// [RULE11] zero delay follows next cycle
	filter_off_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
		(sel == SMBC_GD_OFF && s2_q != lvl) |=> lvl == $past(s2_q))
		else $error("unfiltered line did not follow");
endmodule
`default_nettype wire

// *** verilog/smbc_clkgen.sv ***
`timescale 1ns/1ns
`default_nettype none
module smbc_clkgen
	import smbc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// control
	input  wire logic        run,
	input  wire logic [15:0] presc,
	input  wire logic        line_i,
	// drive request
	output logic             drive_low
);
	smbc_cg_t    st_q;
	logic [5:0]  acc_q;
	logic        tick;
	logic [15:0] cnt_q;
	logic [15:0] low_len;
	logic [15:0] high_len;
	logic        stopped;
	logic        phase_end;

	// [RULE7] low takes the larger half
	assign high_len = presc >> 1;
	assign low_len = presc - high_len;
	// [RULE5] prescale zero or one stops clock
	assign stopped = (presc <= 16'h0001) || !run;
	assign tick = (acc_q + 6'(SMBC_CLK_NS)) >= 6'(SMBC_TICK_NS);
	// [RULE7] each phase restarts the tick, no early first tick
	assign phase_end = tick && ((st_q == SMBC_CG_LOW && cnt_q + 16'h0001 >= low_len)
		|| (st_q == SMBC_CG_HIGH && line_i && cnt_q + 16'h0001 >= high_len));

	// [RULE4] fractional 32 ns base tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_q <= 6'h00;
		end else if (st_q == SMBC_CG_IDLE || phase_end) begin
			acc_q <= 6'h00;
		end else if (tick) begin
			acc_q <= acc_q + 6'(SMBC_CLK_NS) - 6'(SMBC_TICK_NS);
		end else begin
			acc_q <= acc_q + 6'(SMBC_CLK_NS);
		end
	end

	// [RULE4] period of presc ticks
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= SMBC_CG_IDLE;
			cnt_q <= 16'h0000;
		end else if (stopped) begin
			st_q <= SMBC_CG_IDLE;
			cnt_q <= 16'h0000;
		end else begin
			case (st_q)
				SMBC_CG_IDLE: begin
					st_q <= SMBC_CG_LOW;
					cnt_q <= 16'h0000;
				end
				SMBC_CG_LOW: begin
					if (tick && cnt_q + 16'h0001 >= low_len) begin
						st_q <= SMBC_CG_HIGH;
						cnt_q <= 16'h0000;
					end else if (tick) begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				SMBC_CG_HIGH: begin
					if (tick && line_i && cnt_q + 16'h0001 >= high_len) begin
						st_q <= SMBC_CG_LOW;
						cnt_q <= 16'h0000;
					end else if (tick && line_i) begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				default: begin
					st_q <= SMBC_CG_IDLE;
					cnt_q <= 16'h0000;
				end
			endcase
		end
	end

	assign drive_low = (st_q == SMBC_CG_LOW);

	// [RULE5] stopped clock never driven
	clk_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
		(presc <= 16'h0001) |=> !drive_low)
		else $error("master clock driven while stopped");
	// [RULE7] low leaves only after full half
	low_half_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
		(st_q == SMBC_CG_LOW && !stopped) ##1 (st_q == SMBC_CG_HIGH) |-> $past(cnt_q) + 16'h0001 >= $past(low_len))
		else $error("master clock low phase too short");
endmodule
`default_nettype wire

// *** verilog/smbc_top.sv ***
// Functional notes
// [RULE1] A start or stop seen by the master interface at an unexpected point sets status bit 27, write one clears.
// [RULE2] A bad init checksum or a missing configuration-done command sets status bit 28, write one clears.
// [RULE3] An init load to a register that does not exist sets status bit 29, write one clears.
// [RULE4] The master clock prescaler period is 32 ns times the prescale field in control bits 15:0.
// [RULE5] A prescale of zero or one stops the master clock.
// [RULE6] Boot loads prescale 0x0139 for slow mode and 0x0053 for fast mode.
// [RULE7] The master clock stays low for at least half the prescaler period.
// [RULE8] With control bit 16 set the master carries on whether arbitration is won or lost.
// [RULE9] With control bit 17 set init checksums always pass and raise no error.
// [RULE10] Both interfaces filter clock and data through glitch counters, 1 us by default.
// [RULE11] Slave glitch select bits 19:18: 0 is 1 us, 1 is 100 ns, 2 is no delay, 3 reserved.
// [RULE12] Master glitch select bits 21:20 use the same encoding on the master lines.
// [RULE13] Control bit 22 suppresses timeout detection on master and slave.
// [RULE14] An unexpected nack in a master transaction sets status bit 25, write one clears.
// [RULE15] With timeouts enabled a clock held low past the bus timeout aborts the transaction.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module smbc_top
	import smbc_pkg::*;
#(
	parameter int TIMEOUT_CYC = SMBC_TIMEOUT_CYC
) (
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RSTN,
	input  wire logic        SW_RST,
	// ahb-lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic             IRQ,
	// boot strap
	input  wire logic        BOOT_FAST_MODE,
	// master sequencer side
	input  wire logic        MST_CLK_RUN,
	input  wire logic        MST_SDA_LOW,
	input  wire logic        MST_BIT_PHASE,
	input  wire logic        MST_ACK_SLOT,
	output logic             MST_ARB_LOST,
	output logic             MST_TIMEOUT,
	output logic             MST_SCL_LVL,
	output logic             MST_SDA_LVL,
	// slave engine side
	input  wire logic        SLV_SDA_LOW,
	input  wire logic        SLV_SCL_LOW,
	output logic             SLV_TIMEOUT,
	output logic             SLV_SCL_LVL,
	output logic             SLV_SDA_LVL,
	// eeprom init events
	input  wire logic        INIT_CSUM_BAD,
	input  wire logic        INIT_NO_DONE,
	input  wire logic        INIT_UNMAPPED,
	// open-drain pins
	input  wire logic        MASTER_BUS_CLOCK_PIN_I,
	output logic             MASTER_BUS_CLOCK_PIN_O,
	output logic             MASTER_BUS_CLOCK_PIN_OE_N,
	input  wire logic        MASTER_BUS_DATA_PIN_I,
	output logic             MASTER_BUS_DATA_PIN_O,
	output logic             MASTER_BUS_DATA_PIN_OE_N,
	input  wire logic        SLAVE_BUS_CLOCK_PIN_I,
	output logic             SLAVE_BUS_CLOCK_PIN_O,
	output logic             SLAVE_BUS_CLOCK_PIN_OE_N,
	input  wire logic        SLAVE_BUS_DATA_PIN_I,
	output logic             SLAVE_BUS_DATA_PIN_O,
	output logic             SLAVE_BUS_DATA_PIN_OE_N
);
	logic [31:0] ctrl_q;
	logic [31:0] stat_q;
	logic [31:0] mask_q;
	logic [31:0] stat_set;
	logic [31:0] stat_clr;
	logic [31:0] rd_d;
	logic        ph_wr_q;
	logic [11:0] ph_addr_q;
	logic        acc_en;
	logic        wr_ctrl;
	logic        wr_stat;
	logic        wr_mask;
	logic        strap1_q;
	logic        strap2_q;
	logic [1:0]  boot_cnt_q;
	logic        booted_q;
	logic        m_scl;
	logic        m_sda;
	logic        s_scl;
	logic        s_sda;
	logic        m_scl_p_q;
	logic        m_sda_p_q;
	logic        m_cg_low;
	logic        cond_start;
	logic        cond_stop;
	logic        scl_rise;
	logic        misplaced;
	logic        nack;
	logic        lost;
	logic        lost_q;
	logic [31:0] m_to_q;
	logic [31:0] s_to_q;
	logic        tod;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RSTN);

	// ahb address phase
	assign acc_en = HSEL && HTRANS[1] && HREADY;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign wr_ctrl = ph_wr_q && ph_addr_q == SMBC_CTRL_OFS;
	assign wr_stat = ph_wr_q && ph_addr_q == SMBC_STAT_OFS;
	assign wr_mask = ph_wr_q && ph_addr_q == SMBC_MASK_OFS;
	assign tod = ctrl_q[SMBC_TOD_BIT];

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			ph_wr_q <= 1'b0;
			ph_addr_q <= 12'h000;
		end else begin
			ph_wr_q <= acc_en && HWRITE;
			ph_addr_q <= HADDR[SMBC_ADDR_W-1:0];
		end
	end

	// read data latched for the data phase, unmapped reads zero
	always_comb begin
		rd_d = 32'h0000_0000;
		if (HADDR[31:SMBC_ADDR_W] == 20'h00000) begin
			case (HADDR[SMBC_ADDR_W-1:0])
				SMBC_CTRL_OFS: rd_d = ctrl_q & SMBC_CTRL_WMASK;
				SMBC_STAT_OFS: rd_d = stat_q;
				SMBC_MASK_OFS: rd_d = mask_q;
				default:       rd_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			HRDATA <= 32'h0000_0000;
		end else if (acc_en && !HWRITE) begin
			HRDATA <= rd_d;
		end
	end

	// boot strap sync
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			strap1_q <= 1'b0;
			strap2_q <= 1'b0;
			boot_cnt_q <= 2'b00;
			booted_q <= 1'b0;
		end else begin
			strap1_q <= BOOT_FAST_MODE;
			strap2_q <= strap1_q;
			if (boot_cnt_q != 2'(SMBC_BOOT_WAIT)) begin
				boot_cnt_q <= boot_cnt_q + 2'b01;
			end
			booted_q <= boot_cnt_q == 2'(SMBC_BOOT_WAIT);
		end
	end

	// control register, sticky fields survive SW_RST
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			ctrl_q <= 32'h0000_0000;
		end else if (boot_cnt_q == 2'(SMBC_BOOT_WAIT) && !booted_q) begin
			// [RULE6] boot prescale from strap
			ctrl_q[SMBC_PRESC_MSB:SMBC_PRESC_LSB] <= strap2_q ? SMBC_PRESC_FAST : SMBC_PRESC_SLOW;
		end else if (wr_ctrl) begin
			ctrl_q <= HWDATA & SMBC_CTRL_WMASK;
		end else if (SW_RST) begin
			ctrl_q[SMBC_TOD_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			mask_q <= 32'h0000_0000;
		end else if (wr_mask) begin
			mask_q <= HWDATA & SMBC_FLAG_MASK;
		end else if (SW_RST) begin
			mask_q <= 32'h0000_0000;
		end
	end

	// glitch filters
	// [RULE11] slave select
	smbc_glitch u_s_scl (.clk(MCLK), .rst_n(RSTN), .pin_i(SLAVE_BUS_CLOCK_PIN_I),
		.sel(ctrl_q[SMBC_SGD_LSB +: 2]), .lvl(s_scl));
	smbc_glitch u_s_sda (.clk(MCLK), .rst_n(RSTN), .pin_i(SLAVE_BUS_DATA_PIN_I),
		.sel(ctrl_q[SMBC_SGD_LSB +: 2]), .lvl(s_sda));
	// [RULE12] master select
	smbc_glitch u_m_scl (.clk(MCLK), .rst_n(RSTN), .pin_i(MASTER_BUS_CLOCK_PIN_I),
		.sel(ctrl_q[SMBC_MGD_LSB +: 2]), .lvl(m_scl));
	smbc_glitch u_m_sda (.clk(MCLK), .rst_n(RSTN), .pin_i(MASTER_BUS_DATA_PIN_I),
		.sel(ctrl_q[SMBC_MGD_LSB +: 2]), .lvl(m_sda));

	// master clock generator
	smbc_clkgen u_cg (.clk(MCLK), .rst_n(RSTN), .run(MST_CLK_RUN && !MST_TIMEOUT),
		.presc(ctrl_q[SMBC_PRESC_MSB:SMBC_PRESC_LSB]), .line_i(m_scl), .drive_low(m_cg_low));

	// master line events
	assign cond_start = m_scl && m_scl_p_q && m_sda_p_q && !m_sda;
	assign cond_stop = m_scl && m_scl_p_q && !m_sda_p_q && m_sda;
	assign scl_rise = m_scl && !m_scl_p_q;
	// [RULE1] condition during a bit
	assign misplaced = (cond_start || cond_stop) && MST_BIT_PHASE;
	// [RULE14] released data at ack clock
	assign nack = scl_rise && MST_ACK_SLOT && m_sda;
	// [RULE8] lost unless arbitration ignored
	assign lost = scl_rise && !MST_SDA_LOW && !MST_ACK_SLOT && MST_BIT_PHASE && !m_sda
		&& !ctrl_q[SMBC_IGN_ARB_BIT];

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			m_scl_p_q <= 1'b1;
			m_sda_p_q <= 1'b1;
			lost_q <= 1'b0;
		end else begin
			m_scl_p_q <= m_scl;
			m_sda_p_q <= m_sda;
			if (lost) begin
				lost_q <= 1'b1;
			end else if (!MST_CLK_RUN) begin
				lost_q <= 1'b0;
			end
		end
	end

	// pin drivers, low only
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			MASTER_BUS_CLOCK_PIN_OE_N <= 1'b1;
			MASTER_BUS_DATA_PIN_OE_N <= 1'b1;
			SLAVE_BUS_CLOCK_PIN_OE_N <= 1'b1;
			SLAVE_BUS_DATA_PIN_OE_N <= 1'b1;
			MST_ARB_LOST <= 1'b0;
		end else begin
			MASTER_BUS_CLOCK_PIN_OE_N <= !m_cg_low;
			MASTER_BUS_DATA_PIN_OE_N <= !(MST_SDA_LOW && !lost_q && !lost);
			SLAVE_BUS_CLOCK_PIN_OE_N <= !SLV_SCL_LOW;
			SLAVE_BUS_DATA_PIN_OE_N <= !SLV_SDA_LOW;
			MST_ARB_LOST <= lost;
		end
	end

	assign MASTER_BUS_CLOCK_PIN_O = 1'b0;
	assign MASTER_BUS_DATA_PIN_O = 1'b0;
	assign SLAVE_BUS_CLOCK_PIN_O = 1'b0;
	assign SLAVE_BUS_DATA_PIN_O = 1'b0;
	assign MST_SCL_LVL = m_scl;
	assign MST_SDA_LVL = m_sda;
	assign SLV_SCL_LVL = s_scl;
	assign SLV_SDA_LVL = s_sda;

	// [RULE15] clock-low timeout counters
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			m_to_q <= 32'h0000_0000;
			s_to_q <= 32'h0000_0000;
			MST_TIMEOUT <= 1'b0;
			SLV_TIMEOUT <= 1'b0;
		end else begin
			// [RULE13] disable clears and blocks
			m_to_q <= (m_scl || tod) ? 32'h0000_0000 : m_to_q + 32'h0000_0001;
			s_to_q <= (s_scl || tod) ? 32'h0000_0000 : s_to_q + 32'h0000_0001;
			MST_TIMEOUT <= !tod && !m_scl && m_to_q == 32'(TIMEOUT_CYC - 1);
			SLV_TIMEOUT <= !tod && !s_scl && s_to_q == 32'(TIMEOUT_CYC - 1);
		end
	end

	// status flags, set beats clear
	always_comb begin
		stat_set = 32'h0000_0000;
		// [RULE14] nack flag
		stat_set[SMBC_NAK_BIT] = nack;
		// [RULE1] misplaced condition flag
		stat_set[SMBC_MIS_BIT] = misplaced;
		// [RULE2] [RULE9] checksum flag
		stat_set[SMBC_ICS_BIT] = (INIT_CSUM_BAD && !ctrl_q[SMBC_IGN_CSUM_BIT]) || INIT_NO_DONE;
		// [RULE3] unmapped init flag
		stat_set[SMBC_UIA_BIT] = INIT_UNMAPPED;
	end

	assign stat_clr = wr_stat ? (HWDATA & SMBC_FLAG_MASK) : (SW_RST ? SMBC_FLAG_MASK : 32'h0000_0000);

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			stat_q <= 32'h0000_0000;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | stat_set;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(((stat_q & ~stat_clr) | stat_set) & mask_q);
		end
	end

	sequence clr_write_s;
		ph_wr_q && ph_addr_q == SMBC_STAT_OFS;
	endsequence

	irq_level_a: assert property (##1 IRQ == |($past(stat_q & ~stat_clr | stat_set) & $past(mask_q)))
		else $error("interrupt does not follow masked status");
	nack_flag_a: assert property (nack |=> stat_q[SMBC_NAK_BIT]) // [RULE14]
		else $error("nack did not set flag");
	misplaced_flag_a: assert property (misplaced |=> stat_q[SMBC_MIS_BIT]) // [RULE1]
		else $error("misplaced condition did not set flag");
	csum_ignore_a: assert property ((ctrl_q[SMBC_IGN_CSUM_BIT] && !INIT_NO_DONE && !stat_q[SMBC_ICS_BIT]) // [RULE9]
		|=> !stat_q[SMBC_ICS_BIT])
		else $error("ignored checksum raised error");
	csum_flag_a: assert property ((INIT_NO_DONE || INIT_CSUM_BAD && !ctrl_q[SMBC_IGN_CSUM_BIT]) // [RULE2]
		|=> stat_q[SMBC_ICS_BIT])
		else $error("checksum error not flagged");
	unmapped_flag_a: assert property (clr_write_s ##0 (HWDATA[SMBC_UIA_BIT] && !INIT_UNMAPPED) // [RULE3]
		|=> !stat_q[SMBC_UIA_BIT])
		else $error("unmapped flag not cleared by write one");
	boot_presc_a: assert property ($rose(booted_q) && !$past(wr_ctrl) |-> // [RULE6]
		ctrl_q[SMBC_PRESC_MSB:SMBC_PRESC_LSB] == ($past(strap2_q) ? SMBC_PRESC_FAST : SMBC_PRESC_SLOW))
		else $error("boot prescale wrong");
	timeout_off_a: assert property (tod ##1 tod |-> !MST_TIMEOUT && !SLV_TIMEOUT) // [RULE13]
		else $error("timeout while disabled");
	arb_ignore_a: assert property (ctrl_q[SMBC_IGN_ARB_BIT] |=> !MST_ARB_LOST) // [RULE8]
		else $error("arbitration loss reported while ignored");
	m_timeout_a: assert property (!tod && !m_scl && m_to_q == 32'(TIMEOUT_CYC - 1) |=> MST_TIMEOUT) // [RULE15]
		else $error("master timeout missed");
endmodule
`default_nettype wire

// *** sim/smbc_bus_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module smbc_bus_model (
	// design pull enables, low pulls the line
	input  wire logic       mcl_oe_n,
	input  wire logic       mda_oe_n,
	input  wire logic       scl_oe_n,
	input  wire logic       sda_oe_n,
	// far-side pulls: master clk, master data, slave clk, slave data
	input  wire logic [3:0] dev_low,
	// wired-and levels, pulled up once released
	output logic            mcl,
	output logic            mda,
	output logic            scl,
	output logic            sda
);
	// far side stretches or holds a line low on command
	assign mcl = mcl_oe_n & ~dev_low[0];
	assign mda = mda_oe_n & ~dev_low[1];
	assign scl = scl_oe_n & ~dev_low[2];
	assign sda = sda_oe_n & ~dev_low[3];
endmodule
`default_nettype wire

// *** sim/smbus_control_status_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module smbus_control_status_tb
	import smbc_pkg::*;
();
	localparam int TMO = 200;
	logic             mclk, rstn, hsel, hwrite, boot_fast, clk_run, sda_low, bit_phase, ack_slot, slv_scl_low;
	logic      [1:0]  htrans;
	logic      [31:0] haddr, hwdata, rdv;
	logic      [2:0]  init_ev;
	logic      [3:0]  dev_low;
	wire logic [31:0] hrdata;
	wire logic        hreadyout, irq, arb_lost, m_tmo, s_tmo, m_sda, s_sda;
	wire logic [3:0]  oe_n, lines;
	int               mismatches, check_count;
	int               n_arb = 0;
	int               n_mt = 0;
	int               n_st = 0;

	smbc_top #(.TIMEOUT_CYC(TMO)) u_smbc_top (
		.MCLK(mclk), .RSTN(rstn), .SW_RST(1'b0), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(), .IRQ(irq), .BOOT_FAST_MODE(boot_fast),
		.MST_CLK_RUN(clk_run), .MST_SDA_LOW(sda_low), .MST_BIT_PHASE(bit_phase), .MST_ACK_SLOT(ack_slot),
		.MST_ARB_LOST(arb_lost), .MST_TIMEOUT(m_tmo), .MST_SCL_LVL(), .MST_SDA_LVL(m_sda),
		.SLV_SDA_LOW(1'b0), .SLV_SCL_LOW(slv_scl_low), .SLV_TIMEOUT(s_tmo), .SLV_SCL_LVL(), .SLV_SDA_LVL(s_sda),
		.INIT_CSUM_BAD(init_ev[0]), .INIT_NO_DONE(init_ev[1]), .INIT_UNMAPPED(init_ev[2]),
		.MASTER_BUS_CLOCK_PIN_I(lines[0]), .MASTER_BUS_CLOCK_PIN_O(), .MASTER_BUS_CLOCK_PIN_OE_N(oe_n[0]),
		.MASTER_BUS_DATA_PIN_I(lines[1]), .MASTER_BUS_DATA_PIN_O(), .MASTER_BUS_DATA_PIN_OE_N(oe_n[1]),
		.SLAVE_BUS_CLOCK_PIN_I(lines[2]), .SLAVE_BUS_CLOCK_PIN_O(), .SLAVE_BUS_CLOCK_PIN_OE_N(oe_n[2]),
		.SLAVE_BUS_DATA_PIN_I(lines[3]), .SLAVE_BUS_DATA_PIN_O(), .SLAVE_BUS_DATA_PIN_OE_N(oe_n[3])
	);

	smbc_bus_model u_smbc_bus_model (
		.mcl_oe_n(oe_n[0]), .mda_oe_n(oe_n[1]), .scl_oe_n(oe_n[2]), .sda_oe_n(oe_n[3]),
		.dev_low(dev_low), .mcl(lines[0]), .mda(lines[1]), .scl(lines[2]), .sda(lines[3])
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// pulse counters
	always @(posedge mclk) begin
		n_arb <= n_arb + 32'(arb_lost === 1'b1);
		n_mt <= n_mt + 32'(m_tmo === 1'b1);
		n_st <= n_st + 32'(s_tmo === 1'b1);
	end

	task automatic wrap_up;
		if (mismatches == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			wrap_up();
		end
	endtask

	// one single word transfer, read data left in rdv
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rdv = hrdata;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask

	function automatic logic [31:0] cv(input logic [15:0] p, input logic [1:0] ig, input logic [1:0] g,
		input logic tod);
		cv = {9'h0, tod, g, g, ig[1], ig[0], p};
	endfunction

	task automatic ev(input logic [2:0] p);
		init_ev <= p;
		@(posedge mclk);
		init_ev <= 3'b000;
		@(posedge mclk);
	endtask

	// edges while the master clock enable stays at v
	task automatic span(input logic v, output int n);
		n = 0;
		while (oe_n[0] === v && n < 600) begin
			@(posedge mclk);
			n++;
		end
	endtask

	task automatic t_regs;
		rd_chk(SMBC_CTRL_OFS, {16'h0, SMBC_PRESC_SLOW});
		rd_chk(SMBC_STAT_OFS, 32'h0);
		bus(1'b1, 12'had0, 32'hffff_ffff);
		rd_chk(12'had0, 32'h0);
		bus(1'b1, SMBC_CTRL_OFS, 32'hffff_ffff);
		rd_chk(SMBC_CTRL_OFS, SMBC_CTRL_WMASK);
	endtask

	task automatic t_glitch;
		int ns, nm, nx;
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, SMBC_CTRL_OFS, cv(16'h0139, 2'b00, 2'(s), 1'b0));
			nx = (s == 2) ? 0 : (s == 1) ? SMBC_GL_SHORT_CYC : SMBC_GL_LONG_CYC;
			dev_low <= 4'b1010;
			ns = 0;
			nm = 0;
			for (int n = 1; n <= 120; n++) begin
				@(posedge mclk);
				if (s_sda === 1'b1) ns = n;
				if (m_sda === 1'b1) nm = n;
			end
			chk(32'(ns >= nx + 2 && ns <= nx + 4), 32'h1);
			chk(32'(nm >= nx + 2 && nm <= nx + 4), 32'h1);
			dev_low <= 4'b0000;
			repeat (120) @(posedge mclk);
		end
	endtask

	task automatic t_events;
		bus(1'b1, SMBC_MASK_OFS, SMBC_FLAG_MASK);
		bus(1'b1, SMBC_CTRL_OFS, cv(16'h0139, 2'b10, 2'b10, 1'b0));
		ev(3'b001);
		rd_chk(SMBC_STAT_OFS, 32'h0);
		ev(3'b100);
		rd_chk(SMBC_STAT_OFS, 32'h2000_0000);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, SMBC_MASK_OFS, 32'h0);
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, SMBC_STAT_OFS, 32'h2000_0000);
		ev(3'b010);
		rd_chk(SMBC_STAT_OFS, 32'h1000_0000);
		bus(1'b1, SMBC_CTRL_OFS, cv(16'h0139, 2'b00, 2'b10, 1'b0));
		bus(1'b1, SMBC_STAT_OFS, 32'h1000_0000);
		rd_chk(SMBC_STAT_OFS, 32'h0);
		ev(3'b001);
		rd_chk(SMBC_STAT_OFS, 32'h1000_0000);
		bus(1'b1, SMBC_STAT_OFS, 32'hffff_ffff);
		bus(1'b1, SMBC_MASK_OFS, SMBC_FLAG_MASK);
	endtask

	task automatic t_clock;
		int lo, hi, n;
		logic [15:0] p;
		logic [15:0] pt [4];
		pt = '{16'h0000, 16'h0001, 16'h0004, SMBC_PRESC_FAST};
		for (int i = 0; i < 4; i++) begin
			p = pt[i];
			bus(1'b1, SMBC_CTRL_OFS, cv(p, 2'b00, 2'b10, 1'b0));
			ack_slot <= (i > 1);
			dev_low <= {2'b00, i == 2, 1'b0};
			clk_run <= 1'b1;
			span(1'b1, n);
			if (i < 2) begin
				chk(32'(n), 32'd600);
			end else begin
				span(1'b0, n);
				span(1'b1, n);
				span(1'b0, lo);
				span(1'b1, hi);
				chk(32'(lo * 10 >= p * 16 && lo * 10 <= (p - p / 2) * 32 + 20), 32'h1);
				chk(32'((lo + hi) * 10 >= p * 32 && (lo + hi) * 10 <= p * 32 + 100), 32'h1);
			end
			clk_run <= 1'b0;
			repeat (10) @(posedge mclk);
			rd_chk(SMBC_STAT_OFS, (i == 3) ? 32'h0200_0000 : 32'h0);
			chk({31'h0, irq}, 32'(i == 3));
		end
		ack_slot <= 1'b0;
		dev_low <= 4'b0000;
	endtask

	task automatic t_cond;
		int a0;
		bus(1'b1, SMBC_STAT_OFS, 32'hffff_ffff);
		bit_phase <= 1'b1;
		sda_low <= 1'b1;
		repeat (10) @(posedge mclk);
		rd_chk(SMBC_STAT_OFS, 32'h0800_0000);
		bit_phase <= 1'b0;
		dev_low <= 4'b0010;
		@(posedge mclk);
		sda_low <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, SMBC_CTRL_OFS, cv(16'h0004, {1'b0, i == 1}, 2'b10, 1'b0));
			a0 = n_arb;
			bit_phase <= 1'b1;
			clk_run <= 1'b1;
			repeat (100) @(posedge mclk);
			clk_run <= 1'b0;
			bit_phase <= 1'b0;
			chk(32'(n_arb > a0), 32'(i == 0));
		end
		repeat (10) @(posedge mclk);
		dev_low <= 4'b0000;
	endtask

	task automatic t_timeout;
		int s0, m0, ts, tm;
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, SMBC_CTRL_OFS, cv(16'h0004, 2'b00, 2'b10, i == 1));
			s0 = n_st;
			m0 = n_mt;
			ts = 0;
			tm = 0;
			slv_scl_low <= 1'b1;
			dev_low <= 4'b0001;
			for (int n = 1; n <= 400; n++) begin
				@(posedge mclk);
				if (ts == 0 && n_st != s0) ts = n;
				if (tm == 0 && n_mt != m0) tm = n;
			end
			slv_scl_low <= 1'b0;
			dev_low <= 4'b0000;
			chk(32'(i ? ts == 0 : ts > TMO && ts <= TMO + 10), 32'h1);
			chk(32'(i ? tm == 0 : tm > TMO && tm <= TMO + 10), 32'h1);
		end
	endtask

	task automatic t_boot;
		boot_fast <= 1'b1;
		rstn <= 1'b0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		repeat (6) @(posedge mclk);
		rd_chk(SMBC_CTRL_OFS, {16'h0, SMBC_PRESC_FAST});
	endtask

	initial begin
		{rstn, hsel, hwrite, boot_fast, clk_run, sda_low, bit_phase, ack_slot, slv_scl_low} = 9'h000;
		htrans = 2'b00;
		haddr = 32'h0;
		hwdata = 32'h0;
		init_ev = 3'b000;
		dev_low = 4'b0000;
		mismatches = 0;
		check_count = 0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		repeat (6) @(posedge mclk);
		t_regs();
		t_glitch();
		t_events();
		t_clock();
		t_cond();
		t_timeout();
		t_boot();
		wrap_up();
	end
endmodule
`default_nettype wire
